// ==== rtl/scan_start_status.sv ====
/*
 * start and status registers behind the asynchronous strobe port.
 * assumes engines run on clock; rst_b is the synchronized internal reset.
 */
`default_nettype none
`include "scan_regs_map.svh"
module scan_start_status
	import scan_regs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [4:0] address,
	input wire logic [15:0] dataIn,
	output logic [15:0] dataOut,
	output logic dataOe,
	input wire logic chipEnable_b,
	input wire logic readWrite,
	input wire logic strobe_b,
	output logic ackOut,
	output logic ackOe,
	input wire scan_regs_pkg::engine_status_t engine,
	input wire logic [`BUFFER_LEVEL_WIDTH-1:0] outLevel,
	input wire logic [`BUFFER_LEVEL_WIDTH-1:0] inLevel,
	output scan_regs_pkg::start_ctrl_t control
);
	import scan_regs_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] syncA, syncB;
	// address and data ride the same two stages as the strobes
	logic [4:0] addrA, regAddr;
	logic [15:0] dataA, wrData;
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncA <= 3'h7;
			syncB <= 3'h7;
			addrA <= 5'h00;
			regAddr <= 5'h00;
			dataA <= 16'h0000;
			wrData <= 16'h0000;
		end
		else
		begin
			syncA <= {chipEnable_b, strobe_b, readWrite};
			syncB <= syncA;
			addrA <= address;
			regAddr <= addrA;
			dataA <= dataIn;
			wrData <= dataA;
		end
	end
	logic selected;
	assign selected = !syncB[2] && !syncB[1];

	// ----------------------------------------
	// strobe handshake
	// ----------------------------------------
	port_state_t state, next_state;
	logic access;
	always_comb
	begin
		next_state = state;
		access = 1'b0;
		unique case (state)
			PORT_IDLE:
				if (selected)
				begin
					next_state = PORT_ACK;
					access = 1'b1;
				end
			PORT_ACK:
				if (!selected)
					next_state = PORT_IDLE;
			PORT_WAIT:
				next_state = PORT_IDLE;
			default:
				next_state = PORT_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state <= PORT_IDLE;
		else
			state <= next_state;
	end
	// address and data lag the strobes equally, so sample at access
	logic wrStart, wrStatus, isWrite;
	assign isWrite = !syncB[0];
	assign wrStart = access && isWrite && regAddr == `START_OFFSET;
	assign wrStatus = access && isWrite && regAddr == `STATUS_OFFSET;

	// ----------------------------------------
	// start register
	// ----------------------------------------
	logic selfTestStart, sequencerEnable;
	logic [2:0] vectorSelect;
	logic resultWritten;
	assign resultWritten = engine.selfTestDone;
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sequencerEnable <= 1'b0;
			vectorSelect <= 3'h0;
		end
		else if (wrStart)
		begin
			sequencerEnable <= wrData[`START_SEQUENCER_BIT];
			vectorSelect <= wrData[`START_VECTOR_MSB:0];
		end
	end
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			selfTestStart <= 1'b0;
		else if (resultWritten)
			selfTestStart <= 1'b0;
		else if (wrStart)
			selfTestStart <= wrData[`START_SELFTEST_BIT];
	end
	assign control = '{selfTestStart, sequencerEnable, vectorSelect};

	// ----------------------------------------
	// status register
	// ----------------------------------------
	logic [3:0] fillFlags;
	status_flags levels (
		.clock(clock),
		.rst_b(rst_b),
		.outLevel(outLevel),
		.inLevel(inLevel),
		.flags(fillFlags)
	);
	logic compareMatch, running, result, seqActive;
	logic [3:0] bufFlags;
	logic [2:0] vectorRunning;
	// hardware events win over debug writes
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			compareMatch <= 1'b0;
		else if (engine.sequencerStart)
			compareMatch <= 1'b0;
		else if (engine.compareDone)
			compareMatch <= engine.compareMatch;
		else if (wrStatus)
			compareMatch <= wrData[`STATUS_COMPARE_BIT];
	end
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			running <= 1'b0;
			result <= 1'b0;
		end
		else if (engine.selfTestDone)
		begin
			running <= 1'b0;
			result <= engine.selfTestPass;
		end
		else if (wrStatus)
		begin
			running <= wrData[`STATUS_RUNNING_BIT];
			result <= wrData[`STATUS_RESULT_BIT];
		end
		else
			running <= engine.selfTestRunning;
	end
	// follows sequencer, cleared at completion; debug write
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seqActive <= 1'b0;
			vectorRunning <= 3'h0;
			bufFlags <= 4'h0;
		end
		else if (wrStatus)
		begin
			seqActive <= wrData[`STATUS_SEQ_ACTIVE_BIT];
			vectorRunning <= wrData[2:0];
			bufFlags <= wrData[`STATUS_OUT_HALF_BIT:`STATUS_IN_HALF_BIT];
		end
		else
		begin
			seqActive <= engine.sequencerActive;
			vectorRunning <= engine.vectorRunning;
			bufFlags <= fillFlags;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// reserved start bits zero
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			dataOut <= 16'h0000;
		else if (access)
		begin
			if (regAddr == `START_OFFSET)
				dataOut <= {2'h0, selfTestStart, 4'h0, sequencerEnable, 5'h00, vectorSelect};
			else if (regAddr == `STATUS_OFFSET)
				dataOut <= {compareMatch, running, result, bufFlags, seqActive,
					5'h00, vectorRunning};
			else
				dataOut <= 16'h0000;
		end
	end
	assign dataOe = state == PORT_ACK && syncB[0];
	assign ackOut = 1'b0;
	assign ackOe = state == PORT_ACK;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_selftest_clear: assert property (@(posedge clock) disable iff (!rst_b)
		engine.selfTestDone |=> !selfTestStart) else $error("self-test bit not cleared");
	chk_seq_enable: assert property (@(posedge clock) disable iff (!rst_b)
		wrStart && !resultWritten |=> sequencerEnable == $past(wrData[`START_SEQUENCER_BIT]))
		else $error("sequencer enable not stored");
	chk_vector_sel: assert property (@(posedge clock) disable iff (!rst_b)
		wrStart |=> vectorSelect == $past(wrData[2:0])) else $error("vector not stored");
	chk_start_reserved: assert property (@(posedge clock) disable iff (!rst_b)
		access && regAddr == `START_OFFSET |=> (dataOut & 16'hde00) == 16'h0 ##0
		dataOut[7:3] == 5'h0) else $error("start reserved nonzero");
	chk_compare_force: assert property (@(posedge clock) disable iff (!rst_b)
		engine.sequencerStart |=> !compareMatch) else $error("compare not forced");
	chk_compare_match: assert property (@(posedge clock) disable iff (!rst_b)
		engine.compareDone && !engine.sequencerStart |=> compareMatch == $past(engine.compareMatch))
		else $error("compare result wrong");
	chk_half_flag: assert property (@(posedge clock) disable iff (!rst_b)
		inLevel >= 12'h038 && !wrStatus ##1 !wrStatus |=> bufFlags[0])
		else $error("half-full flag missing");
	chk_status_reserved: assert property (@(posedge clock) disable iff (!rst_b)
		access && regAddr == `STATUS_OFFSET |=> dataOut[7:3] == 5'h0)
		else $error("status reserved nonzero");
	chk_seq_active: assert property (@(posedge clock) disable iff (!rst_b)
		!engine.sequencerActive && !wrStatus |=> !seqActive) else $error("seq bit stuck");
	chk_running_flag: assert property (@(posedge clock) disable iff (!rst_b)
		engine.selfTestDone |=> !running) else $error("running bit stuck");
	cov_selftest: cover property (@(posedge clock) disable iff (!rst_b)
		wrStart ##[1:50] engine.selfTestDone);
	cov_status_read: cover property (@(posedge clock) disable iff (!rst_b)
		access && !isWrite && regAddr == `STATUS_OFFSET);
	cov_compare: cover property (@(posedge clock) disable iff (!rst_b)
		engine.sequencerStart ##[1:50] engine.compareDone);
endmodule // scan_start_status
`default_nettype wire

// ==== rtl/scan_regs_map.svh ====
/*
 * register offsets, field positions, reset values and thresholds of the
 * start/status register pair. assumes inclusion from the flag module and top.
 */
`ifndef SCAN_REGS_MAP_SVH
`define SCAN_REGS_MAP_SVH

`define START_OFFSET 5'h00
`define STATUS_OFFSET 5'h01

`define START_SELFTEST_BIT 13
`define START_SEQUENCER_BIT 8
`define START_VECTOR_MSB 2
`define START_RESET 16'h0000

`define STATUS_COMPARE_BIT 15
`define STATUS_RUNNING_BIT 14
`define STATUS_RESULT_BIT 13
`define STATUS_OUT_HALF_BIT 12
`define STATUS_OUT_EMPTY_BIT 11
`define STATUS_IN_FULL_BIT 10
`define STATUS_IN_HALF_BIT 9
`define STATUS_SEQ_ACTIVE_BIT 8
`define STATUS_RESET 16'h0000

`define HALF_THRESHOLD_WORDS 7'h38
`define BUFFER_LEVEL_WIDTH 12

`endif

// ==== rtl/scan_regs_pkg.sv ====
/*
 * types shared by the start/status register pair.
 * assumes the map header is on the include path.
 */
`default_nettype none
package scan_regs_pkg;
	typedef enum logic [1:0] {
		PORT_IDLE = 2'b00,
		PORT_ACK = 2'b01,
		PORT_WAIT = 2'b10
	} port_state_t;

	typedef struct packed {
		logic selfTestStart;
		logic sequencerEnable;
		logic [2:0] vectorSelect;
	} start_ctrl_t;

	typedef struct packed {
		logic compareDone;
		logic compareMatch;
		logic sequencerStart;
		logic selfTestRunning;
		logic selfTestDone;
		logic selfTestPass;
		logic sequencerActive;
		logic [2:0] vectorRunning;
	} engine_status_t;
endpackage
`default_nettype wire

// ==== rtl/status_flags.sv ====
/*
 * derives the buffer fill flags from occupancy counts.
 * assumes the counts are on the system clock.
 */
`default_nettype none
`include "scan_regs_map.svh"
module status_flags
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [`BUFFER_LEVEL_WIDTH-1:0] outLevel,
	input wire logic [`BUFFER_LEVEL_WIDTH-1:0] inLevel,
	output logic [3:0] flags
);
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			flags <= 4'h0;
		else
			flags <= {outLevel <= `BUFFER_LEVEL_WIDTH'(`HALF_THRESHOLD_WORDS),
				outLevel == '0, inLevel == '1,
				inLevel >= `BUFFER_LEVEL_WIDTH'(`HALF_THRESHOLD_WORDS)};
	end
endmodule // status_flags
`default_nettype wire

// ==== bench/host_port_model.sv ====
/*
 host side of the strobe port: one access task per transfer.
 assumes the bench clock paces the host and the acknowledge has a pull-up.
*/
`default_nettype none
module host_port_model
(
	input wire logic clock,
	output logic [4:0] address,
	output logic [15:0] dataIn,
	output logic chipEnable_b,
	output logic readWrite,
	output logic strobe_b,
	input wire logic [15:0] dataOut,
	input wire logic dataOe,
	input wire logic ackOut,
	input wire logic ackOe
);
	timeunit 1ns;
	timeprecision 1ns;
	// open drain: released line floats up
	wire logic ackLine = ackOe ? ackOut : 1'b1;
	initial
	begin
		address = 5'h00;
		dataIn = 16'h0000;
		chipEnable_b = 1'b1;
		readWrite = 1'b1;
		strobe_b = 1'b1;
	end
	task automatic access(input logic rw, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int n;
		@(posedge clock);
		address <= a;
		dataIn <= d;
		readWrite <= rw;
		chipEnable_b <= 1'b0;
		strobe_b <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ackLine !== 1'b0 && n < 20);
		ok = (ackLine === 1'b0);
		q = dataOe ? dataOut : 16'hxxxx;
		chipEnable_b <= 1'b1;
		strobe_b <= 1'b1;
		// released bus must not look like held data
		dataIn <= ~d;
		address <= ~a;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ackLine !== 1'b1 && n < 20);
		ok = ok && (ackLine === 1'b1);
		repeat (3) @(posedge clock);
	endtask
endmodule // host_port_model
`default_nettype wire

// ==== bench/tb.sv ====
/*
 self-checking bench of the start/status pair.
 assumes the host model drives the port and the bench plays the engines.
*/
`default_nettype none
`include "scan_regs_map.svh"
module tb
	import scan_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_b, chipEnable_b, readWrite, strobe_b, dataOe, ackOe, ackOut;
	logic [4:0] address;
	logic [15:0] dataIn, dataOut;
	logic [11:0] outLevel, inLevel;
	engine_status_t engine;
	start_ctrl_t control;
	int errTotal = 0;
	int samplesChecked = 0;
	logic [11:0] lvO [3] = '{12'h038, 12'h039, 12'h100};
	logic [11:0] lvI [3] = '{12'h038, 12'h037, 12'hfff};
	logic [15:0] lvE [3] = '{16'h1200, 16'h0000, 16'h0600};
	scan_start_status scan_start_status_inst (.clock(clock), .rst_b(rst_b),
		.address(address), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.chipEnable_b(chipEnable_b), .readWrite(readWrite), .strobe_b(strobe_b),
		.ackOut(ackOut), .ackOe(ackOe), .engine(engine), .outLevel(outLevel),
		.inLevel(inLevel), .control(control));
	host_port_model host_port_model_inst (.clock(clock), .address(address),
		.dataIn(dataIn), .chipEnable_b(chipEnable_b), .readWrite(readWrite),
		.strobe_b(strobe_b), .dataOut(dataOut), .dataOe(dataOe), .ackOut(ackOut),
		.ackOe(ackOe));
	always #5 clock = ~clock;
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		samplesChecked++;
		if (g !== e)
		begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic ok;
		host_port_model_inst.access(1'b0, a, d, q, ok);
		cmp("handshake", 16'h0001, {15'h0, ok});
	endtask
	task automatic rd(input string n, input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] e);
		logic [15:0] q;
		logic ok;
		host_port_model_inst.access(1'b1, a, 16'h0000, q, ok);
		cmp("handshake", 16'h0001, {15'h0, ok});
		cmp(n, e, q & m);
	endtask
	task automatic pulse(input logic [2:0] s);
		@(posedge clock);
		{engine.sequencerStart, engine.selfTestDone, engine.compareDone} <= s;
		@(posedge clock);
		{engine.sequencerStart, engine.selfTestDone, engine.compareDone} <= 3'b000;
	endtask
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		errTotal++;
		endOfTest();
	end
	initial
	begin
		clock = 1'b0;
		rst_b = 1'b0;
		engine = '0;
		outLevel = 12'h100;
		inLevel = 12'h000;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		rd("start", `START_OFFSET, 16'hffff, 16'h0000);
		rd("status", `STATUS_OFFSET, 16'hf7ff, 16'h0000);
		wr(`START_OFFSET, 16'hfffc);
		rd("start", `START_OFFSET, 16'hffff, 16'h2104);
		cmp("control", 16'h001c, {11'h000, control});
		engine.selfTestRunning <= 1'b1;
		rd("running", `STATUS_OFFSET, 16'h6000, 16'h4000);
		engine.selfTestRunning <= 1'b0;
		engine.selfTestPass <= 1'b1;
		pulse(3'b010);
		rd("start", `START_OFFSET, 16'hffff, 16'h0104);
		rd("result", `STATUS_OFFSET, 16'h6000, 16'h2000);
		engine.compareMatch <= 1'b1;
		pulse(3'b001);
		rd("compare", `STATUS_OFFSET, 16'h8000, 16'h8000);
		pulse(3'b100);
		rd("compare", `STATUS_OFFSET, 16'h8000, 16'h0000);
		wr(`STATUS_OFFSET, 16'h8000);
		rd("debug", `STATUS_OFFSET, 16'ha000, 16'h8000);
		for (int i = 0; i < 3; i++)
		begin
			outLevel <= lvO[i];
			inLevel <= lvI[i];
			rd("levels", `STATUS_OFFSET, 16'h1600, lvE[i]);
		end
		engine.sequencerActive <= 1'b1;
		engine.vectorRunning <= 3'b100;
		rd("sequencer", `STATUS_OFFSET, 16'h01ff, 16'h0104);
		engine.sequencerActive <= 1'b0;
		engine.vectorRunning <= 3'b000;
		rd("sequencer", `STATUS_OFFSET, 16'h01ff, 16'h0000);
		rd("unmapped", 5'h1f, 16'hffff, 16'h0000);
		for (int v = 0; v < 5; v++)
		begin
			wr(`START_OFFSET, 16'(v));
			cmp("vector", 16'(v), {13'h0, control.vectorSelect});
		end
		wr(`START_OFFSET, 16'h0103);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd("start", `START_OFFSET, 16'hffff, 16'h0000);
		cmp("control", 16'h0000, {11'h000, control});
		endOfTest();
	end
endmodule // tb
`default_nettype wire
